// ---- srtc_pkg.sv ----
package srtc_pkg;
    localparam int unsigned ADR_W = 10;
    localparam logic [9:0] OFS_CFG = 10'h000;
    localparam logic [9:0] OFS_IEN_CLR = 10'h004;
    localparam logic [9:0] OFS_IEN_SET = 10'h008;
    localparam logic [9:0] OFS_IRQ_FLAG = 10'h00C;
    localparam logic [9:0] OFS_STATUS = 10'h010;
    localparam logic [9:0] OFS_KEY = 10'h014;
    localparam logic [9:0] OFS_PERM = 10'h018;
    localparam logic [9:0] OFS_RAM = 10'h100;
    localparam int unsigned RAM_WORDS = 64;
    localparam int unsigned RAM_AW = 6;
    localparam logic [5:0] RAM_LAST = 6'h3F;
    localparam int unsigned MEM_W = 36;
    localparam int unsigned PAR_LSB = 32;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_REM = 0;
    localparam int unsigned IRQ_ERR = 1;
    localparam int unsigned CFG_TAMP = 0;
    localparam int unsigned CFG_REM = 1;
    localparam logic [1:0] CFG_RST = 2'h3;
    localparam logic [1:0] SYNC_CNT = 2'h2;
    localparam int unsigned ST_INV = 0;
    localparam int unsigned ST_REM = 1;
    localparam int unsigned ST_CFG = 2;

    typedef enum logic [2:0] {
        SRTC_IDLE, SRTC_RD, SRTC_ERASE, SRTC_REM_RD, SRTC_REM_WR
    } srtc_fsm_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
        logic secure;
        logic debug;
    } srtc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
    } srtc_wb_rsp_s;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] q;
    } srtc_sync_s;

    typedef struct packed {
        srtc_fsm_e fsm;
        srtc_wb_rsp_s rsp;
        logic [IRQ_W-1:0] irq_flag;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic acc_err;
        logic clk_req;
        logic [31:0] key;
        logic [31:0] perm;
        logic [1:0] cfg;
        logic [1:0] cfg_pend;
        logic [1:0] cfg_cnt;
        logic inv;
        logic [5:0] idx;
        logic tamp_q;
        logic rem_q;
        logic tamp_pend;
        logic rem_pend;
    } srtc_state_s;
endpackage

// ---- srtc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module srtc_sync
    import srtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] d_i,
    output var logic [1:0] q_o
);
    srtc_sync_s s;
    srtc_sync_s next_s;

    always_comb begin
        next_s.meta = d_i;
        next_s.q = s.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule
`default_nettype wire

// ---- srtc_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module srtc_mem
    import srtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [3:0] be_i,
    input wire logic [RAM_AW-1:0] addr_i,
    input wire logic [MEM_W-1:0] wdata_i,
    output var logic [MEM_W-1:0] rdata_o
);
    // each lane holds one data byte and its parity bit
    logic [MEM_W-1:0] mem [RAM_WORDS];

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (we_i && be_i[i]) begin
                mem[addr_i][8*i +: 8] <= wdata_i[8*i +: 8];
                mem[addr_i][PAR_LSB+i] <= wdata_i[PAR_LSB+i];
            end
        end
        rdata_o <= mem[addr_i];
    end
endmodule
`default_nettype wire

// ---- srtc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module srtc_core
    import srtc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire srtc_wb_req_s wb_req_i,
    output var srtc_wb_rsp_s wb_rsp_o,
    input wire logic secure_attr_i,
    input wire logic wprot_i,
    input wire logic tamper_evt_i,
    input wire logic remanence_evt_i,
    output var logic irq_o,
    output var logic acc_err_o,
    output var logic clk_req_o
);
    srtc_state_s s;
    srtc_state_s next_s;
    logic [1:0] evt_s;
    logic tamp_s;
    logic rem_s;
    logic tamp_ev;
    logic rem_ev;
    logic req;
    logic [9:0] adr_w;
    logic [31:0] sd;
    logic [IRQ_W-1:0] flag_set;
    logic [IRQ_W-1:0] flag_clr;
    logic mem_we;
    logic [3:0] mem_be;
    logic [RAM_AW-1:0] mem_addr;
    logic [MEM_W-1:0] mem_wdata;
    logic [MEM_W-1:0] mem_q;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // scrambling is its own inverse, so one function serves both directions
    function automatic logic [31:0] scr(input logic [31:0] d, input logic [31:0] key,
                                        input logic [31:0] perm, input logic inv);
        return d ^ key ^ perm ^ {32{inv}};
    endfunction

    function automatic logic [3:0] par4(input logic [31:0] d);
        logic [3:0] p;
        for (int i = 0; i < 4; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction

    function automatic logic is_ram(input logic [9:0] a);
        return a[9:8] == OFS_RAM[9:8];
    endfunction

    function automatic logic is_exempt(input logic [9:0] a);
        return is_ram(a) || a == OFS_IRQ_FLAG || a == OFS_KEY || a == OFS_PERM;
    endfunction

    // event lines come straight from the counter, outside this clock
    srtc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({remanence_evt_i, tamper_evt_i}),
        .q_o(evt_s)
    );

    srtc_mem u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .be_i(mem_be),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_q)
    );

    assign tamp_s = evt_s[0];
    assign rem_s = evt_s[1];
    assign adr_w = {wb_req_i.adr[9:2], 2'b00};
    assign sd = scr(wb_req_i.dat, s.key, s.perm, s.inv);

    always_comb begin
        next_s = s;
        next_s.rsp = '0;
        next_s.acc_err = 1'b0;
        flag_set = '0;
        flag_clr = '0;
        mem_we = 1'b0;
        mem_be = 4'h0;
        mem_addr = s.idx;
        mem_wdata = '0;
        tamp_ev = tamp_s & ~s.tamp_q & s.cfg[CFG_TAMP];
        rem_ev = rem_s & ~s.rem_q & s.cfg[CFG_REM];
        next_s.tamp_q = tamp_s;
        next_s.rem_q = rem_s;
        next_s.tamp_pend = s.tamp_pend | tamp_ev;
        next_s.rem_pend = s.rem_pend | rem_ev;
        req = wb_req_i.cyc & wb_req_i.stb & ~s.rsp.ack & ~s.rsp.err;
        if (s.cfg_cnt != 2'h0) begin
            next_s.cfg_cnt = s.cfg_cnt - 2'h1;
            if (s.cfg_cnt == 2'h1) begin
                next_s.cfg = s.cfg_pend;
            end
        end
        if (s.tamp_pend && s.fsm != SRTC_ERASE && s.fsm != SRTC_RD) begin
            // erase wins over bus and aborts the remanence walk
            next_s.fsm = SRTC_ERASE;
            next_s.idx = '0;
            next_s.key = '0;
            next_s.tamp_pend = tamp_ev;
        end else begin
            unique case (s.fsm)
                SRTC_IDLE: begin
                    if (req) begin
                        if (secure_attr_i && !wb_req_i.secure) begin
                            next_s.rsp.ack = 1'b1;
                            next_s.acc_err = 1'b1;
                        end else if (wb_req_i.we && wprot_i && !wb_req_i.debug
                                     && !is_exempt(adr_w)) begin
                            next_s.rsp.err = 1'b1;
                            next_s.acc_err = 1'b1;
                        end else if (is_ram(adr_w)) begin
                            mem_addr = adr_w[7:2];
                            if (wb_req_i.we) begin
                                mem_we = 1'b1;
                                mem_be = wb_req_i.sel;
                                mem_wdata = {par4(sd), sd};
                                next_s.rsp.ack = 1'b1;
                            end else begin
                                next_s.fsm = SRTC_RD;
                            end
                        end else begin
                            next_s.rsp.ack = 1'b1;
                            case (adr_w)
                                OFS_CFG: begin
                                    next_s.rsp.dat = {30'h0, s.cfg};
                                    if (wb_req_i.we) begin
                                        next_s.cfg_pend = wb_req_i.sel[0] ?
                                            wb_req_i.dat[1:0] : s.cfg_pend;
                                        next_s.cfg_cnt = SYNC_CNT;
                                    end
                                end
                                OFS_IEN_CLR: begin
                                    next_s.rsp.dat = {30'h0, s.irq_en};
                                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                                        next_s.irq_en = s.irq_en & ~wb_req_i.dat[1:0];
                                    end
                                end
                                OFS_IEN_SET: begin
                                    next_s.rsp.dat = {30'h0, s.irq_en};
                                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                                        next_s.irq_en = s.irq_en | wb_req_i.dat[1:0];
                                    end
                                end
                                OFS_IRQ_FLAG: begin
                                    next_s.rsp.dat = {30'h0, s.irq_flag};
                                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                                        flag_clr = wb_req_i.dat[1:0];
                                    end
                                end
                                OFS_STATUS: begin
                                    next_s.rsp.dat[ST_INV] = s.inv;
                                    next_s.rsp.dat[ST_REM] = s.rem_pend;
                                    next_s.rsp.dat[ST_CFG] = s.cfg_cnt != 2'h0;
                                end
                                OFS_KEY: begin
                                    // the key never reads back
                                    if (wb_req_i.we) begin
                                        next_s.key = wmerge(s.key, wb_req_i.dat, wb_req_i.sel);
                                    end
                                end
                                OFS_PERM: begin
                                    next_s.rsp.dat = s.perm;
                                    if (wb_req_i.we) begin
                                        next_s.perm = wmerge(s.perm, wb_req_i.dat, wb_req_i.sel);
                                    end
                                end
                                default: begin
                                    next_s.rsp.ack = 1'b0;
                                    next_s.rsp.err = 1'b1;
                                end
                            endcase
                        end
                    end else if (s.rem_pend) begin
                        next_s.fsm = SRTC_REM_RD;
                        next_s.idx = '0;
                        next_s.rem_pend = rem_ev;
                    end
                end
                SRTC_RD: begin
                    next_s.fsm = SRTC_IDLE;
                    next_s.rsp.ack = 1'b1;
                    next_s.rsp.dat = scr(mem_q[31:0], s.key, s.perm, s.inv);
                    if (par4(mem_q[31:0]) != mem_q[MEM_W-1:PAR_LSB]) begin
                        flag_set[IRQ_ERR] = 1'b1;
                    end
                end
                SRTC_ERASE: begin
                    mem_we = 1'b1;
                    mem_be = 4'hF;
                    next_s.key = '0;
                    next_s.idx = s.idx + 6'h1;
                    if (req) begin
                        if (wb_req_i.we && adr_w == OFS_KEY) begin
                            next_s.rsp.ack = 1'b1;
                        end else begin
                            next_s.rsp.err = 1'b1;
                        end
                    end
                    if (s.idx == RAM_LAST) begin
                        next_s.fsm = SRTC_IDLE;
                        next_s.inv = 1'b0;
                    end
                end
                SRTC_REM_RD: begin
                    next_s.fsm = SRTC_REM_WR;
                end
                SRTC_REM_WR: begin
                    // invert data only; eight flips keep byte parity
                    mem_we = 1'b1;
                    mem_be = 4'hF;
                    mem_wdata = {mem_q[MEM_W-1:PAR_LSB], ~mem_q[31:0]};
                    next_s.idx = s.idx + 6'h1;
                    next_s.fsm = SRTC_REM_RD;
                    if (s.idx == RAM_LAST) begin
                        next_s.fsm = SRTC_IDLE;
                        next_s.inv = ~s.inv;
                        flag_set[IRQ_REM] = 1'b1;
                    end
                end
            endcase
        end
        next_s.irq_flag = (s.irq_flag & ~flag_clr) | flag_set;
        next_s.irq = |(next_s.irq_flag & next_s.irq_en);
        next_s.clk_req = next_s.fsm != SRTC_IDLE || next_s.tamp_pend || next_s.rem_pend
                         || next_s.cfg_cnt != 2'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.cfg <= CFG_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp_o = s.rsp;
    assign irq_o = s.irq;
    assign acc_err_o = s.acc_err;
    assign clk_req_o = s.clk_req;

    logic idle_req;
    logic ok_req;
    assign idle_req = s.fsm == SRTC_IDLE && !s.tamp_pend && req;
    assign ok_req = idle_req && !(secure_attr_i && !wb_req_i.secure);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence cfg_wr;
        ok_req && wb_req_i.we && adr_w == OFS_CFG && !wprot_i;
    endsequence
    sequence cfg_wait;
        (s.cfg_cnt != 2'h0) [*2] ##1 (s.cfg == s.cfg_pend && s.cfg_cnt == 2'h0);
    endsequence

    erase_bus_err_a: assert property (
        s.fsm == SRTC_ERASE && req && !(wb_req_i.we && adr_w == OFS_KEY)
        |=> wb_rsp_o.err && !wb_rsp_o.ack)
        else $error("access during erase not refused");
    key_drop_a: assert property (
        s.fsm == SRTC_ERASE && req && wb_req_i.we && adr_w == OFS_KEY
        |=> wb_rsp_o.ack && !wb_rsp_o.err && s.key == 32'h0000_0000)
        else $error("key write during erase not dropped");
    reman_abort_a: assert property (
        (s.fsm == SRTC_REM_RD || s.fsm == SRTC_REM_WR) && s.tamp_pend
        |=> s.fsm == SRTC_ERASE && s.idx == 6'h00)
        else $error("remanence not aborted by tamper");
    reman_done_a: assert property (
        s.fsm == SRTC_REM_WR && s.idx == RAM_LAST && !s.tamp_pend
        |=> s.irq_flag[IRQ_REM] && s.fsm == SRTC_IDLE)
        else $error("remanence done flag missing");
    irq_line_a: assert property (
        irq_o == |(s.irq_flag & s.irq_en))
        else $error("interrupt line disagrees with flags");
    nonsec_drop_a: assert property (
        idle_req && secure_attr_i && !wb_req_i.secure
        |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000 && acc_err_o
            && $stable(s.perm))
        else $error("non-secure access not discarded");
    wprot_err_a: assert property (
        ok_req && wb_req_i.we && wprot_i && !wb_req_i.debug && !is_exempt(adr_w)
        |=> wb_rsp_o.err && acc_err_o && $stable(s.irq_en))
        else $error("protected write not refused");
    dbg_bypass_a: assert property (
        ok_req && wb_req_i.we && wprot_i && wb_req_i.debug && adr_w == OFS_IEN_SET
        |=> wb_rsp_o.ack && !wb_rsp_o.err)
        else $error("debugger write refused");
    flag_clear_a: assert property (
        ok_req && wb_req_i.we && !wprot_i && adr_w == OFS_IRQ_FLAG && wb_req_i.sel[0]
        && wb_req_i.dat[IRQ_REM] |=> !s.irq_flag[IRQ_REM])
        else $error("flag not cleared by write one");
    enable_set_a: assert property (
        ok_req && wb_req_i.we && !wprot_i && adr_w == OFS_IEN_SET && wb_req_i.sel[0]
        && wb_req_i.dat[IRQ_ERR] |=> s.irq_en[IRQ_ERR])
        else $error("enable set failed");
    cfg_sync_a: assert property (
        cfg_wr |=> cfg_wait)
        else $error("shared register applied at wrong time");
    clk_req_a: assert property (
        s.tamp_pend || s.rem_pend |-> clk_req_o)
        else $error("clock not requested for pending event");
    irq_hold_a: assert property (
        irq_o && !(req && wb_req_i.we && (adr_w == OFS_IRQ_FLAG || adr_w == OFS_IEN_CLR))
        |=> irq_o)
        else $error("interrupt dropped without clear or disable");
endmodule
`default_nettype wire

// ---- srtc_rtc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module srtc_rtc_model (
    input wire logic clk_i,
    input wire logic fire_tamper_i,
    input wire logic fire_rem_i,
    output var logic tamper_o,
    output var logic rem_o
);
    logic [2:0] tamp_cnt = 3'h0;
    logic [2:0] rem_cnt = 3'h0;
    // each event is a rising edge held long enough for the two-flop capture
    always @(posedge clk_i) begin
        if (fire_tamper_i) begin
            tamp_cnt <= 3'h6;
        end else if (tamp_cnt != 3'h0) begin
            tamp_cnt <= tamp_cnt - 3'h1;
        end
        if (fire_rem_i) begin
            rem_cnt <= 3'h6;
        end else if (rem_cnt != 3'h0) begin
            rem_cnt <= rem_cnt - 3'h1;
        end
    end
    always_comb begin
        tamper_o = |tamp_cnt;
        rem_o = |rem_cnt;
    end
endmodule
`default_nettype wire

// ---- test_secure_ram_tamper_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_secure_ram_tamper_control;
    import srtc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic secure_attr_i = 1'b0;
    logic wprot_i = 1'b0;
    logic fire_t = 1'b0;
    logic fire_r = 1'b0;
    srtc_wb_req_s req = '0;
    srtc_wb_rsp_s rsp;
    logic irq, acc_err, clk_req, tamp, rem;
    logic got_ack, got_err, got_acc;
    logic [31:0] got_dat;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    srtc_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .secure_attr_i(secure_attr_i), .wprot_i(wprot_i), .tamper_evt_i(tamp),
        .remanence_evt_i(rem), .irq_o(irq), .acc_err_o(acc_err), .clk_req_o(clk_req));
    srtc_rtc_model rtc (.clk_i(clk_i), .fire_tamper_i(fire_t), .fire_rem_i(fire_r),
        .tamper_o(tamp), .rem_o(rem));

    // bus clock runs free here; gating it belongs to the clock controller
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; the answer is taken at the edge that shows ack or err
    task automatic bus(input logic we, input logic [9:0] adr, input logic [31:0] d,
            input logic sec, input logic dbg);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d,
            secure: sec, debug: dbg};
        @(posedge clk_i);
        // only the bench timeout ends a wait for the answer
        while (rsp.ack !== 1'b1 && rsp.err !== 1'b1) begin
            @(posedge clk_i);
        end
        got_ack = rsp.ack;
        got_err = rsp.err;
        got_dat = rsp.dat;
        got_acc = acc_err;
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 400) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic t_protect();
        wprot_i <= 1'b1;
        bus(1'b1, OFS_IEN_SET, 32'h0000_0003, 1'b1, 1'b0);
        chk("prot err", 32'h1, {31'h0, got_err});
        chk("prot acc err", 32'h1, {31'h0, got_acc});
        bus(1'b0, OFS_IEN_CLR, 32'h0, 1'b1, 1'b0);
        chk("prot ien", 32'h0, got_dat);
        bus(1'b1, 10'h1FC, 32'hA5A5_5A5A, 1'b1, 1'b0);
        chk("ram63 ack", 32'h1, {31'h0, got_ack});
        bus(1'b0, 10'h1FC, 32'h0, 1'b1, 1'b0);
        chk("ram63 rd", 32'hA5A5_5A5A, got_dat);
        bus(1'b1, OFS_IRQ_FLAG, 32'h0000_0003, 1'b1, 1'b0);
        chk("flag ack", 32'h1, {31'h0, got_ack});
        bus(1'b1, OFS_IEN_SET, 32'h0000_0001, 1'b1, 1'b1);
        chk("dbg ack", 32'h1, {31'h0, got_ack});
        bus(1'b0, OFS_IEN_CLR, 32'h0, 1'b1, 1'b0);
        chk("dbg ien", 32'h1, got_dat);
        wprot_i <= 1'b0;
    endtask

    task automatic t_secure();
        bus(1'b1, OFS_RAM, 32'h1111_2222, 1'b1, 1'b0);
        secure_attr_i <= 1'b1;
        bus(1'b1, OFS_RAM, 32'h3333_4444, 1'b0, 1'b0);
        chk("ns wr acc err", 32'h1, {31'h0, got_acc});
        bus(1'b0, 10'h1FC, 32'h0, 1'b0, 1'b0);
        chk("ns rd dat", 32'h0, got_dat);
        chk("ns rd acc err", 32'h1, {31'h0, got_acc});
        bus(1'b0, OFS_RAM, 32'h0, 1'b1, 1'b0);
        chk("sec rd dat", 32'h1111_2222, got_dat);
        chk("sec rd acc err", 32'h0, {31'h0, got_acc});
        secure_attr_i <= 1'b0;
    endtask

    task automatic t_irq();
        fire_r <= 1'b1;
        @(posedge clk_i);
        fire_r <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("clk req", 32'h1, {31'h0, clk_req});
        wait_irq(1'b1);
        chk("rem irq", 32'h1, {31'h0, irq});
        bus(1'b0, OFS_IRQ_FLAG, 32'h0, 1'b1, 1'b0);
        chk("flag rd", 32'h1, got_dat);
        bus(1'b1, OFS_IRQ_FLAG, 32'h0, 1'b1, 1'b0);
        chk("flag w0", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_IEN_CLR, 32'h0000_0001, 1'b1, 1'b0);
        chk("ien clr", 32'h0, {31'h0, irq});
        bus(1'b1, OFS_IEN_SET, 32'h0000_0001, 1'b1, 1'b0);
        chk("ien set", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_IRQ_FLAG, 32'h0000_0001, 1'b1, 1'b0);
        chk("flag w1", 32'h0, {31'h0, irq});
        bus(1'b0, OFS_IRQ_FLAG, 32'h0, 1'b1, 1'b0);
        chk("flag clr", 32'h0, got_dat);
    endtask

    task automatic t_tamper();
        fire_r <= 1'b1;
        @(posedge clk_i);
        fire_r <= 1'b0;
        repeat (20) @(posedge clk_i);
        fire_t <= 1'b1;
        @(posedge clk_i);
        fire_t <= 1'b0;
        repeat (10) @(posedge clk_i);
        bus(1'b1, OFS_KEY, 32'h5A5A_0F0F, 1'b1, 1'b0);
        chk("key ack", 32'h1, {31'h0, got_ack});
        chk("key err", 32'h0, {31'h0, got_err});
        bus(1'b1, OFS_RAM, 32'h0000_00FF, 1'b1, 1'b0);
        chk("erase err", 32'h1, {31'h0, got_err});
        repeat (120) @(posedge clk_i);
        bus(1'b0, OFS_IRQ_FLAG, 32'h0, 1'b1, 1'b0);
        chk("rem aborted", 32'h0, got_dat);
        chk("no irq", 32'h0, {31'h0, irq});
        // after the erase a word reads zero only if the key write was dropped
        bus(1'b0, OFS_RAM, 32'h0, 1'b1, 1'b0);
        chk("erased word", 32'h0, got_dat);
    endtask

    // a config write lands after the sync delay; a masked event starts nothing
    task automatic t_cfg();
        bus(1'b1, OFS_CFG, 32'h0000_0001, 1'b1, 1'b0);
        bus(1'b0, OFS_CFG, 32'h0, 1'b1, 1'b0);
        chk("cfg rd", 32'h1, got_dat);
        fire_r <= 1'b1;
        @(posedge clk_i);
        fire_r <= 1'b0;
        repeat (12) @(posedge clk_i);
        chk("masked clk req", 32'h0, {31'h0, clk_req});
        bus(1'b0, OFS_STATUS, 32'h0, 1'b1, 1'b0);
        chk("status", 32'h0, got_dat);
    endtask

    // standby and its power gating are software's duty, never entered here

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst irq", 32'h0, {31'h0, irq});
        t_protect();
        t_secure();
        t_irq();
        t_tamper();
        t_cfg();
        give_verdict();
    end
endmodule
`default_nettype wire
